// ---- pkg/mbw_regs.svh ----
`ifndef MBW_REGS_SVH
`define MBW_REGS_SVH

// ====
// Check code
`define MBW_CRC_INIT 16'hFFFF
`define MBW_CRC_POLY 16'hA001

// ====
// Function and exception codes
`define MBW_FN_WR_REG 8'h06
`define MBW_FN_WR_COILS 8'h0F
`define MBW_FN_WR_REGS 8'h10
`define MBW_EXC_FLAG 8'h80
`define MBW_EXC_NONE 8'h00
`define MBW_EXC_FUNC 8'h01
`define MBW_EXC_ADDR 8'h02
`define MBW_EXC_VALUE 8'h03

// ====
// Station number and request limits
`define MBW_STATION_MIN 8'h01
`define MBW_STATION_MAX 8'hF7
`define MBW_MAX_COILS 16'h00FF
`define MBW_MAX_REGS 16'h007B

// ====
// Frame byte positions and lengths
`define MBW_POS_STATION 8'h00
`define MBW_POS_FUNC 8'h01
`define MBW_POS_ADDR_HI 8'h02
`define MBW_POS_ADDR_LO 8'h03
`define MBW_POS_CNT_HI 8'h04
`define MBW_POS_CNT_LO 8'h05
`define MBW_POS_BCNT 8'h06
`define MBW_POS_DATA 8'h07
`define MBW_LEN_MIN 9'h004
`define MBW_LEN_SINGLE 9'h008
`define MBW_LEN_MULTI_HDR 9'h009
`define MBW_LEN_CAP 9'h101
`define MBW_ECHO_LEN 9'h006
`define MBW_EXC_LEN 9'h003
`define MBW_HDR_SINGLE 9'h006
`define MBW_HDR_MULTI 9'h007
`define MBW_BITS_LOG2 3
`define MBW_COIL_ROUND 16'h0007
`define MBW_BYTE_ONES 8'hFF
`define MBW_BIT_ONE 8'h01

// ====
// Coil areas: base address and size
`define MBW_COIL_AUX_BASE 16'h0000
`define MBW_COIL_AUX_SIZE 17'h01E00
`define MBW_COIL_SAUX_BASE 16'h1F40
`define MBW_COIL_SAUX_SIZE 17'h00200
`define MBW_COIL_SYS_BASE 16'h2400
`define MBW_COIL_SYS_SIZE 17'h00400
`define MBW_COIL_STEP_BASE 16'hE000
`define MBW_COIL_STEP_SIZE 17'h01000
`define MBW_COIL_TMR_BASE 16'hF000
`define MBW_COIL_TMR_SIZE 17'h00200
`define MBW_COIL_CNT_BASE 16'hF400
`define MBW_COIL_CNT_SIZE 17'h00100
`define MBW_COIL_IN_BASE 16'hF800
`define MBW_COIL_IN_SIZE 17'h00100
`define MBW_COIL_OUT_BASE 16'hFC00
`define MBW_COIL_OUT_SIZE 17'h00100

// ====
// Register areas: base address and size
`define MBW_REG_DATA_BASE 16'h0000
`define MBW_REG_DATA_SIZE 17'h02140
`define MBW_REG_SYS_BASE 16'h2400
`define MBW_REG_SYS_SIZE 17'h00400
`define MBW_REG_EXT_BASE 16'h3000
`define MBW_REG_EXT_SIZE 17'h08000
`define MBW_REG_TMR_BASE 16'hF000
`define MBW_REG_TMR_SIZE 17'h00200
`define MBW_REG_CNT16_BASE 16'hF400
`define MBW_REG_CNT16_SIZE 17'h000C8
`define MBW_REG_CNT32_BASE 16'hF700
`define MBW_REG_CNT32_SIZE 17'h00070

`endif

// ---- pkg/mbw_pkg.sv ----
package mbw_pkg;
  `include "mbw_regs.svh"

  // ====
  // Element areas
  typedef enum logic [3:0] {
    AREA_AUX = 4'h0, AREA_SAUX = 4'h1, AREA_SYS_BIT = 4'h2, AREA_STEP = 4'h3,
    AREA_TMR_BIT = 4'h4, AREA_CNT_BIT = 4'h5, AREA_IN = 4'h6, AREA_OUT = 4'h7,
    AREA_WORD = 4'h8, AREA_SYS_WORD = 4'h9, AREA_EXT_WORD = 4'hA, AREA_TMR_VAL = 4'hB,
    AREA_CNT16 = 4'hC, AREA_CNT32 = 4'hD
  } mbw_area_t;

  typedef struct packed {
    logic ok;
    logic [3:0] area;
    logic [15:0] idx;
  } mbw_map_t;

  localparam logic [15:0] COIL_BASE [8] = '{`MBW_COIL_AUX_BASE, `MBW_COIL_SAUX_BASE, `MBW_COIL_SYS_BASE,
    `MBW_COIL_STEP_BASE, `MBW_COIL_TMR_BASE, `MBW_COIL_CNT_BASE, `MBW_COIL_IN_BASE, `MBW_COIL_OUT_BASE};
  localparam logic [16:0] COIL_SIZE [8] = '{`MBW_COIL_AUX_SIZE, `MBW_COIL_SAUX_SIZE, `MBW_COIL_SYS_SIZE,
    `MBW_COIL_STEP_SIZE, `MBW_COIL_TMR_SIZE, `MBW_COIL_CNT_SIZE, `MBW_COIL_IN_SIZE, `MBW_COIL_OUT_SIZE};
  localparam logic [15:0] REG_BASE [6] = '{`MBW_REG_DATA_BASE, `MBW_REG_SYS_BASE, `MBW_REG_EXT_BASE,
    `MBW_REG_TMR_BASE, `MBW_REG_CNT16_BASE, `MBW_REG_CNT32_BASE};
  localparam logic [16:0] REG_SIZE [6] = '{`MBW_REG_DATA_SIZE, `MBW_REG_SYS_SIZE, `MBW_REG_EXT_SIZE,
    `MBW_REG_TMR_SIZE, `MBW_REG_CNT16_SIZE, `MBW_REG_CNT32_SIZE};

  // ====
  // One byte of the reflected 16-bit check code
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBW_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ====
  // Address to element area; coils map to areas 0..7, registers to 8..13
  function automatic mbw_map_t coil_map(input logic [15:0] a);
    mbw_map_t m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      if (a >= COIL_BASE[i] && {1'b0, a} < ({1'b0, COIL_BASE[i]} + COIL_SIZE[i])) begin
        m.ok = 1'b1;
        m.area = 4'(i);
        m.idx = a - COIL_BASE[i];
      end
    end
    return m;
  endfunction

  function automatic mbw_map_t reg_map(input logic [15:0] a);
    mbw_map_t m;
    m = '0;
    for (int i = 0; i < 6; i++) begin
      if (a >= REG_BASE[i] && {1'b0, a} < ({1'b0, REG_BASE[i]} + REG_SIZE[i])) begin
        m.ok = 1'b1;
        m.area = 4'(AREA_WORD) + 4'(i);
        m.idx = a - REG_BASE[i];
      end
    end
    return m;
  endfunction
endpackage

// ---- pkg/mbw_if.sv ----
`timescale 1ns/1ps
interface mbw_if;
  // Request bytes, master to slave; the slave takes one each valid cycle while in S_RX
  logic req_valid;
  logic [7:0] req_data;
  logic req_last;
  // Response bytes, slave to master
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;
  logic rsp_ready;

  modport slave (input req_valid, req_data, req_last, rsp_ready, output rsp_valid, rsp_data, rsp_last);
  modport master (output req_valid, req_data, req_last, rsp_ready, input rsp_valid, rsp_data, rsp_last);
endinterface

// ---- hw/mbw_slave.sv ----
// Contract
// RULE1 - Accept only own station number, 1 to 247
// RULE2 - Two-byte fields travel high byte first
// RULE3 - Single register write, echo address and value
// RULE4 - Coil write carries count, (N+7)/8 bytes, states
// RULE5 - Coils packed LSB first, spare bits zero
// RULE6 - Coil write reply: station, function, address, count
// RULE7 - At most 255 coils per write
// RULE8 - Register write carries count, 2N bytes, values
// RULE9 - At most 123 registers per write
// RULE10 - Register write reply: station, function, address, count
// RULE11 - Exception reply: station, function plus 0x80, code
// RULE12 - Exception codes only 1 to 4
// RULE13 - Coil map: auxiliary, special auxiliary, step relays
// RULE14 - Coil map: system relays, timer, counter contacts
// RULE15 - Coil map: inputs and outputs, octal numbered
// RULE16 - Register map: data, system, extended data words
// RULE17 - Register map: timer values, 16-bit counters
// RULE18 - 32-bit counters mapped from 0xF700
// RULE19 - 32-bit counter takes two register addresses
// RULE20 - Single write to 32-bit counter rejected
// RULE21 - Wrong station or check code: no reply
// RULE22 - Check code is standard 16-bit CRC
// RULE23 - Out-of-range request gives exception, no write
`timescale 1ns/1ps
module mbw_slave (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // Configuration
  input wire logic [7:0] STATION_NUMBER_SETTING_IN,
  // Serial frame link
  mbw_if.slave LINK,
  // Element memory write port
  output logic ELEM_WE_OUT,
  output logic ELEM_IS_BIT_OUT,
  output logic [3:0] ELEM_AREA_OUT,
  output logic [15:0] ELEM_INDEX_OUT,
  output logic [15:0] ELEM_DATA_OUT
);
  `include "mbw_regs.svh"

  typedef enum logic [3:0] {
    S_RX = 4'h1,
    S_CHK = 4'h2,
    S_WR = 4'h4,
    S_TX = 4'h8
  } mbw_sst_t;

  typedef struct packed {
    mbw_sst_t st;
    logic [255:0][7:0] fb;
    logic [8:0] len;
    logic [15:0] crc;
    logic [7:0] d0;
    logic [7:0] d1;
    logic exc;
    logic [7:0] code;
    logic [3:0] area;
    logic [15:0] base;
    logic [15:0] n;
    logic [15:0] i;
    logic we;
    logic ebit;
    logic [3:0] earea;
    logic [15:0] eidx;
    logic [15:0] edata;
    logic [7:0] tdat;
    logic [8:0] ti;
    logic [15:0] tcrc;
  } mbw_slv_t;

  localparam mbw_slv_t RST_VAL = '{st: S_RX, crc: `MBW_CRC_INIT, tcrc: `MBW_CRC_INIT, default: '0};

  mbw_slv_t q;
  mbw_slv_t d;

  // ====
  // Request decode
  logic [7:0] fn;
  logic [15:0] addr;
  logic [15:0] cnt;
  logic [7:0] bc;
  logic [15:0] last_addr;
  logic [8:0] multi_len;
  logic [15:0] coil_bytes;
  logic st_ok;
  logic fr_ok;
  mbw_pkg::mbw_map_t cf;
  mbw_pkg::mbw_map_t cl;
  mbw_pkg::mbw_map_t rf;
  mbw_pkg::mbw_map_t rl;

  always_comb begin
    fn = q.fb[`MBW_POS_FUNC];
    addr = {q.fb[`MBW_POS_ADDR_HI], q.fb[`MBW_POS_ADDR_LO]}; // see RULE2
    cnt = {q.fb[`MBW_POS_CNT_HI], q.fb[`MBW_POS_CNT_LO]}; // see RULE2
    bc = q.fb[`MBW_POS_BCNT];
    last_addr = addr + cnt - 16'h0001;
    multi_len = `MBW_LEN_MULTI_HDR + {1'b0, bc};
    coil_bytes = (cnt + `MBW_COIL_ROUND) >> `MBW_BITS_LOG2;
    cf = mbw_pkg::coil_map(addr); // see RULE13 see RULE14 see RULE15
    cl = mbw_pkg::coil_map(last_addr);
    rf = mbw_pkg::reg_map(addr); // see RULE16 see RULE17 see RULE18
    rl = mbw_pkg::reg_map(last_addr);
    st_ok = (q.fb[`MBW_POS_STATION] == STATION_NUMBER_SETTING_IN)
      && (STATION_NUMBER_SETTING_IN >= `MBW_STATION_MIN)
      && (STATION_NUMBER_SETTING_IN <= `MBW_STATION_MAX); // see RULE1
    fr_ok = st_ok && (q.len >= `MBW_LEN_MIN) && ({q.d1, q.d0} == q.crc); // see RULE21 see RULE22
  end

  // ====
  // Next state
  logic [7:0] code;
  logic [8:0] tlen;
  logic [8:0] tnxt;
  logic [7:0] wpos;

  always_comb begin
    d = q;
    d.we = 1'b0;
    code = `MBW_EXC_NONE;
    tlen = q.exc ? `MBW_EXC_LEN : `MBW_ECHO_LEN;
    tnxt = q.ti + 9'h001;
    wpos = `MBW_POS_DATA + {q.i[6:0], 1'b0};
    unique case (q.st)
      S_RX: begin
        if (LINK.req_valid) begin
          if (q.len < 9'h100) begin
            d.fb[q.len[7:0]] = LINK.req_data;
          end
          if (q.len != `MBW_LEN_CAP) begin
            d.len = q.len + 9'h001;
          end
          // The last two bytes stay in the pipe until the frame ends
          if (q.len >= 9'h002) begin
            d.crc = mbw_pkg::crc_step(q.crc, q.d1); // see RULE22
          end
          d.d1 = q.d0;
          d.d0 = LINK.req_data;
          if (LINK.req_last) begin
            d.st = S_CHK;
          end
        end
      end
      S_CHK: begin
        if (!fr_ok) begin
          d.st = S_RX; // see RULE21
          d.len = '0;
          d.crc = `MBW_CRC_INIT;
        end else begin
          if (fn == `MBW_FN_WR_REG) begin
            if (q.len != `MBW_LEN_SINGLE) begin
              code = `MBW_EXC_VALUE;
            end else if (!rf.ok || rf.area == 4'(mbw_pkg::AREA_CNT32)) begin
              code = `MBW_EXC_ADDR; // see RULE20
            end
            d.area = rf.area;
            d.base = rf.idx;
            d.n = 16'h0001;
          end else if (fn == `MBW_FN_WR_COILS) begin
            if (cnt == 16'h0000 || cnt > `MBW_MAX_COILS || {8'h00, bc} != coil_bytes
                || q.len != multi_len) begin
              code = `MBW_EXC_VALUE; // see RULE7 see RULE4
            end else if (!cf.ok || !cl.ok || cl.area != cf.area || cl.idx < cf.idx) begin
              code = `MBW_EXC_ADDR; // see RULE23
            end
            d.area = cf.area;
            d.base = cf.idx;
            d.n = cnt;
          end else if (fn == `MBW_FN_WR_REGS) begin
            if (cnt == 16'h0000 || cnt > `MBW_MAX_REGS || {8'h00, bc} != {cnt[14:0], 1'b0}
                || q.len != multi_len) begin
              code = `MBW_EXC_VALUE; // see RULE9 see RULE8
            end else if (!rf.ok || !rl.ok || rl.area != rf.area || rl.idx < rf.idx) begin
              code = `MBW_EXC_ADDR; // see RULE23 see RULE19
            end
            d.area = rf.area;
            d.base = rf.idx;
            d.n = cnt;
          end else begin
            code = `MBW_EXC_FUNC; // see RULE12
          end
          d.code = code;
          d.exc = (code != `MBW_EXC_NONE);
          d.i = '0;
          d.ti = '0;
          d.tcrc = `MBW_CRC_INIT;
          d.tdat = q.fb[`MBW_POS_STATION];
          d.st = (code != `MBW_EXC_NONE) ? S_TX : S_WR; // see RULE23
        end
      end
      S_WR: begin
        d.we = 1'b1;
        d.earea = q.area;
        d.eidx = q.base + q.i; // see RULE15 see RULE19
        d.ebit = (fn == `MBW_FN_WR_COILS);
        if (fn == `MBW_FN_WR_REG) begin
          d.edata = cnt; // see RULE3
        end else if (fn == `MBW_FN_WR_COILS) begin
          d.edata = {15'h0000, q.fb[`MBW_POS_DATA + q.i[10:3]][q.i[2:0]]}; // see RULE5
        end else begin
          d.edata = {q.fb[wpos], q.fb[wpos + 8'h01]}; // see RULE2
        end
        d.i = q.i + 16'h0001;
        if (q.i == q.n - 16'h0001) begin
          d.st = S_TX;
        end
      end
      S_TX: begin
        if (LINK.rsp_ready) begin
          d.ti = tnxt;
          if (q.ti < tlen) begin
            d.tcrc = mbw_pkg::crc_step(q.tcrc, q.tdat); // see RULE22
          end
          if (tnxt < tlen) begin
            if (q.exc && tnxt == 9'(`MBW_POS_FUNC)) begin
              d.tdat = fn | `MBW_EXC_FLAG; // see RULE11
            end else if (q.exc) begin
              d.tdat = q.code; // see RULE12
            end else begin
              d.tdat = q.fb[tnxt[7:0]]; // see RULE3 see RULE6 see RULE10
            end
          end else if (tnxt == tlen) begin
            d.tdat = d.tcrc[15:8]; // see RULE2
          end else begin
            d.tdat = q.tcrc[7:0];
          end
          if (q.ti == tlen + 9'h001) begin
            d.st = S_RX;
            d.len = '0;
            d.crc = `MBW_CRC_INIT;
          end
        end
      end
    endcase
  end

  // ====
  // State register
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  // ====
  // Outputs
  assign LINK.rsp_valid = (q.st == S_TX);
  assign LINK.rsp_data = q.tdat;
  assign LINK.rsp_last = (q.st == S_TX) && (q.ti == tlen + 9'h001);
  assign ELEM_WE_OUT = q.we;
  assign ELEM_IS_BIT_OUT = q.ebit;
  assign ELEM_AREA_OUT = q.earea;
  assign ELEM_INDEX_OUT = q.eidx;
  assign ELEM_DATA_OUT = q.edata;
endmodule

// ---- hw/mbw_master.sv ----
`timescale 1ns/1ps
module mbw_master (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // Command
  input wire logic CMD_VALID_IN,
  input wire logic [7:0] CMD_STATION_IN,
  input wire logic [7:0] CMD_FUNC_IN,
  input wire logic [15:0] CMD_ADDR_IN,
  input wire logic [15:0] CMD_COUNT_IN,
  output logic CMD_READY_OUT,
  // Payload bytes
  input wire logic USR_BYTE_VALID_IN,
  input wire logic [7:0] USR_BYTE_IN,
  output logic USR_BYTE_READY_OUT,
  // Response status
  output logic RSP_DONE_OUT,
  output logic RSP_CRC_OK_OUT,
  output logic [7:0] RSP_EXC_CODE_OUT,
  // Serial frame link
  mbw_if.master LINK
);
  `include "mbw_regs.svh"

  typedef enum logic [2:0] {
    M_IDLE = 3'h1,
    M_TX = 3'h2,
    M_RX = 3'h4
  } mbw_mst_t;

  typedef struct packed {
    mbw_mst_t st;
    logic [7:0] station;
    logic [7:0] fn;
    logic [15:0] addr;
    logic [15:0] cnt;
    logic [7:0] bc;
    logic [8:0] k;
    logic [8:0] hlen;
    logic [15:0] crc;
    logic vq;
    logic [7:0] dq;
    logic lq;
    logic [8:0] rlen;
    logic [15:0] rcrc;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] rfn;
    logic [7:0] rcode;
    logic done;
    logic ok;
    logic [7:0] exc;
  } mbw_mst_q_t;

  localparam mbw_mst_q_t RST_VAL = '{st: M_IDLE, crc: `MBW_CRC_INIT, rcrc: `MBW_CRC_INIT, default: '0};

  mbw_mst_q_t q;
  mbw_mst_q_t d;
  logic pay;
  logic [7:0] tb;
  logic [7:0] mask;
  logic [15:0] bsum;
  logic [15:0] rcrc_n;

  always_comb begin
    d = q;
    d.vq = 1'b0;
    d.lq = 1'b0;
    d.done = 1'b0;
    pay = (q.st == M_TX) && (q.k >= `MBW_HDR_MULTI) && (q.k < q.hlen) && (q.fn != `MBW_FN_WR_REG);
    mask = (q.cnt[2:0] == 3'h0) ? `MBW_BYTE_ONES : ((`MBW_BIT_ONE << q.cnt[2:0]) - `MBW_BIT_ONE);
    bsum = (CMD_COUNT_IN + `MBW_COIL_ROUND) >> `MBW_BITS_LOG2;
    rcrc_n = (q.rlen >= 9'h002) ? mbw_pkg::crc_step(q.rcrc, q.r1) : q.rcrc;
    if (q.k == q.hlen) begin
      tb = q.crc[15:8]; // see RULE2
    end else if (q.k == q.hlen + 9'h001) begin
      tb = q.crc[7:0];
    end else if (pay) begin
      tb = USR_BYTE_IN;
      if (q.fn == `MBW_FN_WR_COILS && q.k == q.hlen - 9'h001) begin
        tb = USR_BYTE_IN & mask; // see RULE5
      end
    end else begin
      unique case (q.k[2:0])
        3'h0: tb = q.station;
        3'h1: tb = q.fn;
        3'h2: tb = q.addr[15:8]; // see RULE2
        3'h3: tb = q.addr[7:0];
        3'h4: tb = q.cnt[15:8];
        3'h5: tb = q.cnt[7:0];
        default: tb = q.bc;
      endcase
    end
    unique case (q.st)
      M_IDLE: begin
        if (CMD_VALID_IN) begin
          d.station = CMD_STATION_IN;
          d.fn = CMD_FUNC_IN;
          d.addr = CMD_ADDR_IN;
          d.cnt = CMD_COUNT_IN;
          d.bc = (CMD_FUNC_IN == `MBW_FN_WR_COILS) ? bsum[7:0] : {CMD_COUNT_IN[6:0], 1'b0}; // see RULE4 see RULE8
          d.hlen = (CMD_FUNC_IN == `MBW_FN_WR_REG) ? `MBW_HDR_SINGLE : `MBW_HDR_MULTI + {1'b0, d.bc};
          d.k = '0;
          d.crc = `MBW_CRC_INIT;
          d.st = M_TX;
        end
      end
      M_TX: begin
        if (!pay || USR_BYTE_VALID_IN) begin
          d.vq = 1'b1;
          d.dq = tb;
          d.k = q.k + 9'h001;
          if (q.k < q.hlen) begin
            d.crc = mbw_pkg::crc_step(q.crc, tb); // see RULE22
          end
          if (q.k == q.hlen + 9'h001) begin
            d.lq = 1'b1;
            d.st = M_RX;
            d.rlen = '0;
            d.rcrc = `MBW_CRC_INIT;
          end
        end
      end
      M_RX: begin
        if (LINK.rsp_valid) begin
          d.rlen = q.rlen + 9'h001;
          d.rcrc = rcrc_n;
          d.r1 = q.r0;
          d.r0 = LINK.rsp_data;
          if (q.rlen == 9'(`MBW_POS_FUNC)) begin
            d.rfn = LINK.rsp_data;
          end
          if (q.rlen == 9'(`MBW_POS_ADDR_HI)) begin
            d.rcode = LINK.rsp_data;
          end
          if (LINK.rsp_last) begin
            d.done = 1'b1;
            d.ok = ({q.r0, LINK.rsp_data} == rcrc_n); // see RULE2
            d.exc = d.rfn[7] ? d.rcode : `MBW_EXC_NONE; // see RULE11
            d.st = M_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  assign CMD_READY_OUT = (q.st == M_IDLE);
  assign USR_BYTE_READY_OUT = pay;
  assign LINK.req_valid = q.vq;
  assign LINK.req_data = q.dq;
  assign LINK.req_last = q.lq;
  assign LINK.rsp_ready = (q.st == M_RX);
  assign RSP_DONE_OUT = q.done;
  assign RSP_CRC_OK_OUT = q.ok;
  assign RSP_EXC_CODE_OUT = q.exc;
endmodule

// ---- tb/mbw_assertions.sv ----
`timescale 1ns/1ps
module mbw_assertions (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // Configuration
  input wire logic [7:0] STATION_NUMBER_SETTING_IN,
  // Link
  input wire logic req_valid,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_ready
);
  logic [15:0] qc, qa, sc, sa;
  logic [7:0] qp, sp;
  logic [3:0] rc;
  logic fx;
  wire st = rsp_valid && rsp_ready;

  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction

  // ====
  // Check code two bytes back covers the frame body
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      {qc, qa, sc, sa} <= {4{16'hFFFF}};
      {qp, sp, rc, fx} <= '0;
    end else begin
      if (req_valid) begin
        qa <= qc;
        qp <= req_data;
        qc <= req_last ? 16'hFFFF : crc_b(qc, req_data);
      end
      if (st) begin
        sa <= sc;
        sp <= rsp_data;
        sc <= rsp_last ? 16'hFFFF : crc_b(sc, rsp_data);
        rc <= rsp_last ? 4'h0 : rc + 4'h1;
        if (rc == 4'h1) begin
          fx <= rsp_data[7];
        end
      end
    end
  end

  // ====
  // Properties
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  a_rsp_station: assert property ($rose(rsp_valid) |-> rsp_data == STATION_NUMBER_SETTING_IN)
    else $error("bad station byte");
  a_req_crc: assert property (req_valid && req_last |-> {qp, req_data} == qa)
    else $error("bad request check code");
  a_rsp_crc: assert property (st && rsp_last |-> {sp, rsp_data} == sa)
    else $error("bad response check code");
  a_func_echo: assert property (st && rc == 4'h1 |-> rsp_data inside {8'h06, 8'h0F, 8'h10, 8'h86, 8'h8F, 8'h90})
    else $error("bad function byte");
  a_exc_code: assert property (st && rc == 4'h2 && fx |-> rsp_data inside {[8'h01:8'h04]})
    else $error("bad exception code");
  a_rsp_length: assert property (st && rsp_last |-> rc == (fx ? 4'h4 : 4'h7))
    else $error("bad response length");
  a_rsp_stands: assert property (rsp_valid && !(rsp_ready && rsp_last) |=> rsp_valid)
    else $error("response dropped early");
  a_half_duplex: assert property (req_valid |-> !rsp_valid)
    else $error("reply during request");
  a_rsp_delay: assert property (req_valid && req_last |=> !rsp_valid)
    else $error("reply too early");

  c_exc: cover property (st && rsp_last && fx);
  c_echo: cover property (st && rsp_last && !fx);
  c_start: cover property ($rose(rsp_valid));
endmodule

// ---- tb/tb_modbus_slave_write_handler.sv ----
`timescale 1ns/1ps
module tb_modbus_slave_write_handler;
  typedef logic [7:0] mbw_bq_t[$];
  logic clk, rstn, cv, uv;
  logic [7:0] stn, cs, cf, ub;
  logic [15:0] ca, cc;
  wire cr, ur, dn, ok, we, wb;
  wire [7:0] ec;
  wire [3:0] wa;
  wire [15:0] wi, wd;
  int n_mismatch = 0;
  int comparisons = 0;
  int pi, cyc;
  mbw_bq_t pl, rq, qq;
  logic [15:0] ea[$], ei[$], ed[$];
  mbw_if lk();
  mbw_if lk_b();

  mbw_master u_mbw_master (.CLK_IN(clk), .RSTN_IN(rstn), .CMD_VALID_IN(cv), .CMD_STATION_IN(cs), .CMD_FUNC_IN(cf),
    .CMD_ADDR_IN(ca), .CMD_COUNT_IN(cc), .CMD_READY_OUT(cr), .USR_BYTE_VALID_IN(uv), .USR_BYTE_IN(ub),
    .USR_BYTE_READY_OUT(ur), .RSP_DONE_OUT(dn), .RSP_CRC_OK_OUT(ok), .RSP_EXC_CODE_OUT(ec), .LINK(lk.master));
  mbw_slave u_mbw_slave (.CLK_IN(clk), .RSTN_IN(rstn), .STATION_NUMBER_SETTING_IN(stn), .LINK(lk.slave),
    .ELEM_WE_OUT(we), .ELEM_IS_BIT_OUT(wb), .ELEM_AREA_OUT(wa), .ELEM_INDEX_OUT(wi), .ELEM_DATA_OUT(wd));
  mbw_slave u_mbw_slave_b (.CLK_IN(clk), .RSTN_IN(rstn), .STATION_NUMBER_SETTING_IN(stn), .LINK(lk_b.slave),
    .ELEM_WE_OUT(), .ELEM_IS_BIT_OUT(), .ELEM_AREA_OUT(), .ELEM_INDEX_OUT(), .ELEM_DATA_OUT());
  mbw_assertions u_mbw_assertions (.CLK_IN(clk), .RSTN_IN(rstn), .STATION_NUMBER_SETTING_IN(stn),
    .req_valid(lk.req_valid), .req_data(lk.req_data), .req_last(lk.req_last), .rsp_valid(lk.rsp_valid),
    .rsp_data(lk.rsp_data), .rsp_last(lk.rsp_last), .rsp_ready(lk.rsp_ready));

  // ====
  // Checking helpers
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmpq(input string nm, input mbw_bq_t s, input mbw_bq_t e);
    chk(nm, 16'(s.size()), 16'(e.size()));
    foreach (e[i]) chk(nm, {8'h00, s[i]}, {8'h00, e[i]});
  endtask

  function automatic mbw_bq_t seal(input mbw_bq_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    return q;
  endfunction

  task results();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic rst();
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
  endtask

  // ====
  // Monitors, payload feeder and cycle limit
  always @(posedge clk) begin
    if (lk.req_valid === 1'b1) qq.push_back(lk.req_data);
    if (lk.rsp_valid === 1'b1 && lk.rsp_ready === 1'b1) rq.push_back(lk.rsp_data);
    if (we === 1'b1) begin
      if (ea.size() == 0) begin
        chk("elem_we", 16'h0001, 16'h0000);
      end else begin
        chk("elem_area", {11'h000, wb, wa}, ea.pop_front());
        chk("elem_index", wi, ei.pop_front());
        chk("elem_data", wb ? {15'h0000, wd[0]} : wd, ed.pop_front());
      end
    end
    if (uv === 1'b1 && ur === 1'b1) pi++;
    if (uv !== 1'b1 || ur === 1'b1) begin
      uv <= pi < pl.size() && $urandom_range(3) != 0;
      ub <= pi < pl.size() ? pl[pi] : 8'h00;
    end
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // ====
  // One request through master and slave, against the model
  task automatic run(input logic [7:0] st, f, input logic [15:0] a, n, input logic [7:0] x,
      input logic [3:0] ar, input logic [15:0] ix);
    logic [15:0] v;
    int nb;
    mbw_bq_t e, r;
    pl.delete();
    rq.delete();
    qq.delete();
    pi = 0;
    v = (f == 8'h06) ? 16'($urandom) : n;
    nb = (f == 8'h0F) ? (n + 7) / 8 : 2 * n;
    if (f != 8'h06) for (int i = 0; i < nb; i++) pl.push_back(8'($urandom));
    if (f == 8'h0F && n % 8 != 0) pl[nb - 1] = pl[nb - 1] & (8'hFF >> (8 - n % 8));
    if (x == 8'h00) for (int i = 0; i < (f == 8'h06 ? 1 : n); i++) begin
      ea.push_back({11'h000, f == 8'h0F, ar});
      ei.push_back(16'(ix + i));
      ed.push_back(f == 8'h0F ? {15'h0000, pl[i / 8][i % 8]} : f == 8'h10 ? {pl[2 * i], pl[2 * i + 1]} : v);
    end
    e = '{st, f, a[15:8], a[7:0], v[15:8], v[7:0]};
    r = e;
    if (f != 8'h06) begin
      r.push_back(8'(nb));
      foreach (pl[i]) r.push_back(pl[i]);
    end
    @(posedge clk);
    cv <= 1'b1;
    cs <= st;
    cf <= f;
    ca <= a;
    cc <= v;
    @(posedge clk);
    while (cr !== 1'b1) @(posedge clk);
    cv <= 1'b0;
    if (x == 8'hFF) begin
      repeat (60) @(posedge clk);
      chk("silent", 16'(rq.size()), 16'h0000);
      cmpq("req", qq, seal(r));
      rst();
    end else begin
      for (int i = 0; i < 3000 && dn !== 1'b1; i++) @(posedge clk);
      chk("done", {15'h0000, dn}, 16'h0001);
      chk("exc", {8'h00, ec}, {8'h00, x});
      chk("crc_ok", {15'h0000, ok}, 16'h0001);
      chk("left", 16'(ea.size()), 16'h0000);
      cmpq("req", qq, seal(r));
      if (x != 8'h00) e = '{st, f | 8'h80, x};
      cmpq("rsp", rq, seal(e));
    end
  endtask

  // ====
  // Far end that breaks the check code on purpose
  task automatic send_b(input logic bad);
    mbw_bq_t q;
    int n = 0;
    q = seal('{stn, 8'h06, 8'h00, 8'h01, 8'h12, 8'h34});
    q[7] = q[7] ^ {7'h00, bad};
    foreach (q[i]) begin
      @(posedge clk);
      lk_b.req_valid <= 1'b1;
      lk_b.req_data <= q[i];
      lk_b.req_last <= (i == 7);
    end
    @(posedge clk);
    lk_b.req_valid <= 1'b0;
    lk_b.req_last <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (lk_b.rsp_valid === 1'b1) n++;
    end
    chk("slave_b_rsp", 16'(n), bad ? 16'h0000 : 16'h0008);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rstn, cv, uv, ub, cs, cf, ca, cc} = '0;
    {lk_b.req_valid, lk_b.req_data, lk_b.req_last} = '0;
    lk_b.rsp_ready = 1'b1;
    void'($urandom(32'h16345F24));
    stn = 8'(1 + $urandom_range(246));
    rst();
    run(stn, 8'h06, 16'h2405, 16'h0000, 8'h00, 4'h9, 16'h0005);
    run(stn, 8'h06, 16'hF4C7, 16'h0000, 8'h00, 4'hC, 16'h00C7);
    run(stn, 8'h06, 16'hF700, 16'h0000, 8'h02, 4'h0, 16'h0000);
    run(stn, 8'h0F, 16'hFCF8, 16'h0008, 8'h00, 4'h7, 16'h00F8);
    run(stn, 8'h0F, 16'h1F40, 16'h00FF, 8'h00, 4'h1, 16'h0000);
    run(stn, 8'h0F, 16'h0000, 16'h0100, 8'h03, 4'h0, 16'h0000);
    run(stn, 8'h0F, 16'hFCFC, 16'h0005, 8'h02, 4'h0, 16'h0000);
    run(stn, 8'h0F, 16'h27FE, 16'h0002, 8'h00, 4'h2, 16'h03FE);
    run(stn, 8'h0F, 16'hE000, 16'h000D, 8'h00, 4'h3, 16'h0000);
    run(stn, 8'h0F, 16'hF1FF, 16'h0001, 8'h00, 4'h4, 16'h01FF);
    run(stn, 8'h0F, 16'hF4FE, 16'h0002, 8'h00, 4'h5, 16'h00FE);
    run(stn, 8'h0F, 16'hF807, 16'h0003, 8'h00, 4'h6, 16'h0007);
    run(stn, 8'h10, 16'hF70A, 16'h0008, 8'h00, 4'hD, 16'h000A);
    run(stn, 8'h10, 16'hF000, 16'h007B, 8'h00, 4'hB, 16'h0000);
    run(stn, 8'h10, 16'h0000, 16'h007C, 8'h03, 4'h0, 16'h0000);
    run(stn, 8'h10, 16'h213F, 16'h0002, 8'h02, 4'h0, 16'h0000);
    run(stn, 8'h10, 16'hAFFF, 16'h0001, 8'h00, 4'hA, 16'h7FFF);
    run(8'(stn + 8'h01), 8'h06, 16'h0001, 16'h0000, 8'hFF, 4'h0, 16'h0000);
    stn <= 8'h00;
    run(8'h00, 8'h06, 16'h0001, 16'h0000, 8'hFF, 4'h0, 16'h0000);
    stn <= 8'hF7;
    run(8'hF7, 8'h10, 16'h0100, 16'h0002, 8'h00, 4'h8, 16'h0100);
    send_b(1'b1);
    send_b(1'b0);
    results();
  end
endmodule
